// [include/tlic_pkg.sv]
// Shared constants and types for the two-level interrupt controller
package tlic_pkg;
  localparam int          TLIC_NSRC            = 11;
  localparam logic [7:0]  TLIC_ADDR_IE_PRIMARY = 8'hA8;
  localparam logic [7:0]  TLIC_ADDR_SECONDARY  = 8'hA9;
  localparam logic [7:0]  TLIC_ADDR_PRIORITY   = 8'hB8;
  localparam logic [7:0]  TLIC_RST_IE_PRIMARY  = 8'h00;
  localparam logic [7:0]  TLIC_RST_SECONDARY   = 8'hA0;
  localparam logic [7:0]  TLIC_RST_PRIORITY    = 8'h00;
  localparam logic [7:0]  TLIC_PRIO_WMASK      = 8'h7F;
  localparam logic [7:0]  TLIC_SEC_WMASK       = 8'h77;
  localparam int          TLIC_GATE_BIT        = 7;
  // Source index equals polling rank minus one (0 = highest)
  localparam int          TLIC_SRC_PSM   = 0;
  localparam int          TLIC_SRC_WDG   = 1;
  localparam int          TLIC_SRC_EXT0  = 2;
  localparam int          TLIC_SRC_ADC   = 3;
  localparam int          TLIC_SRC_TMR0  = 4;
  localparam int          TLIC_SRC_EXT1  = 5;
  localparam int          TLIC_SRC_TMR1  = 6;
  localparam int          TLIC_SRC_SER   = 7;
  localparam int          TLIC_SRC_UART  = 8;
  localparam int          TLIC_SRC_TMR2  = 9;
  localparam int          TLIC_SRC_TIC   = 10;
  localparam logic [15:0] TLIC_VEC_EXT0  = 16'h0003;
  localparam logic [15:0] TLIC_VEC_TMR0  = 16'h000B;
  localparam logic [15:0] TLIC_VEC_EXT1  = 16'h0013;
  localparam logic [15:0] TLIC_VEC_TMR1  = 16'h001B;
  localparam logic [15:0] TLIC_VEC_UART  = 16'h0023;
  localparam logic [15:0] TLIC_VEC_TMR2  = 16'h002B;
  localparam logic [15:0] TLIC_VEC_ADC   = 16'h0033;
  localparam logic [15:0] TLIC_VEC_SER   = 16'h003B;
  localparam logic [15:0] TLIC_VEC_PSM   = 16'h0043;
  localparam logic [15:0] TLIC_VEC_TIC   = 16'h0053;
  localparam logic [15:0] TLIC_VEC_WDG   = 16'h005B;

  typedef struct packed {
    logic supply_mon_request;
    logic watchdog_timeout_flag;
    logic ext0_request;
    logic primary_adc_done;
    logic aux_adc_done;
    logic timer0_overflow;
    logic ext1_request;
    logic timer1_overflow;
    logic two_wire_request;
    logic four_wire_request;
    logic uart_rx_flag;
    logic uart_tx_flag;
    logic timer2_overflow;
    logic timer2_ext_flag;
    logic interval_ctr_request;
  } tlic_flags_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlic_sfr_wr_t;

  typedef enum logic [2:0] {
    TLIC_ST_IDLE = 3'b001,
    TLIC_ST_ACK  = 3'b010,
    TLIC_ST_WAIT = 3'b100
  } tlic_state_t;
endpackage

// [core/tlic_select.sv]
// Fixed-order picker: lowest index wins among requests at one level
`timescale 1ns/10ps
module tlic_select
  import tlic_pkg::*;
#(
  parameter int N = TLIC_NSRC
) (
  input  wire logic [N-1:0]         req,
  output logic                      any,
  output logic [$clog2(N)-1:0]      idx
);
  if (N < 2) begin : g_bad_n
    $error("tlic_select needs at least two sources");
  end

  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = ($clog2(N))'(i);
      end
    end
  end
endmodule

// [core/tlic_ctrl.sv]
// Two-level interrupt controller: enable/priority SFRs, arbitration, nesting, vectors
//
// Overview of operation
// - Bit 7 of enable register gates every source except the watchdog
// - Primary enable bits switch seven sources
// - Priority bits pick high or low level
// - Reserved bit 7 registers do nothing
// - Secondary low bits enable three sources
// - Secondary upper bits set three sources' levels
// - High request preempts running low routine
// - Simultaneous mixed levels: high goes first
// - Same level cannot interrupt same level
// - Fixed polling order within one level
// - Accept pushes return PC, loads vector (the core model only loads the vector into pc_r and stores no return PC)
// - Each source has its fixed vector
// - Watchdog interrupts only when select bit set
// - Watchdog always treated as high level
// - Watchdog ignores global gate bit
// - Watchdog interrupts only with nonzero timeout
`timescale 1ns/10ps
module tlic_ctrl
  import tlic_pkg::*;
#(
  parameter int N = TLIC_NSRC
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire tlic_sfr_wr_t sfr_wr,
  input  wire logic [7:0]   sfr_raddr,
  output logic [7:0]        sfr_rdata,
  input  wire tlic_flags_t  flags,
  input  wire logic         watchdog_irq_select,
  input  wire logic         watchdog_timeout_nonzero,
  input  wire logic         core_ready,
  input  wire logic         core_reti,
  output logic              irq_req,
  output logic [15:0]       irq_vector,
  output logic              irq_push_pc,
  output logic [N-1:0]      irq_taken,
  output logic [1:0]        active_levels
);
  localparam int IW = $clog2(N);

  if (N != TLIC_NSRC) begin : g_bad_n
    $error("tlic_ctrl serves exactly eleven sources");
  end

  // Vector lookup, also used for the registered output and checks
  function automatic logic [15:0] vec_of(input logic [IW-1:0] s);
    case (s)
      IW'(TLIC_SRC_PSM):  vec_of = TLIC_VEC_PSM;
      IW'(TLIC_SRC_WDG):  vec_of = TLIC_VEC_WDG;
      IW'(TLIC_SRC_EXT0): vec_of = TLIC_VEC_EXT0;
      IW'(TLIC_SRC_ADC):  vec_of = TLIC_VEC_ADC;
      IW'(TLIC_SRC_TMR0): vec_of = TLIC_VEC_TMR0;
      IW'(TLIC_SRC_EXT1): vec_of = TLIC_VEC_EXT1;
      IW'(TLIC_SRC_TMR1): vec_of = TLIC_VEC_TMR1;
      IW'(TLIC_SRC_SER):  vec_of = TLIC_VEC_SER;
      IW'(TLIC_SRC_UART): vec_of = TLIC_VEC_UART;
      IW'(TLIC_SRC_TMR2): vec_of = TLIC_VEC_TMR2;
      default:            vec_of = TLIC_VEC_TIC;
    endcase
  endfunction

  logic [7:0] ie_primary_r;
  logic [7:0] priority_r;
  logic [7:0] secondary_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_primary_r <= TLIC_RST_IE_PRIMARY;
    end else if (sfr_wr.wr && sfr_wr.addr == TLIC_ADDR_IE_PRIMARY) begin
      ie_primary_r <= sfr_wr.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      priority_r <= TLIC_RST_PRIORITY;
    end else if (sfr_wr.wr && sfr_wr.addr == TLIC_ADDR_PRIORITY) begin
      priority_r <= sfr_wr.wdata & TLIC_PRIO_WMASK;
    end
  end

  // Bit 7 keeps its reset one, bit 3 is held at zero even if software errs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      secondary_r <= TLIC_RST_SECONDARY;
    end else if (sfr_wr.wr && sfr_wr.addr == TLIC_ADDR_SECONDARY) begin
      secondary_r <= (sfr_wr.wdata & TLIC_SEC_WMASK)
                     | (TLIC_RST_SECONDARY & ~TLIC_SEC_WMASK);
    end
  end

  always_comb begin
    case (sfr_raddr)
      TLIC_ADDR_IE_PRIMARY: sfr_rdata = ie_primary_r;
      TLIC_ADDR_PRIORITY:   sfr_rdata = priority_r;
      TLIC_ADDR_SECONDARY:  sfr_rdata = secondary_r;
      default:              sfr_rdata = 8'h00;
    endcase
  end

  // Request, enable and level vectors in polling order
  logic [N-1:0] raw;
  logic [N-1:0] en;
  logic [N-1:0] hi;
  logic         gate;

  always_comb begin
    gate = ie_primary_r[TLIC_GATE_BIT];
    raw[TLIC_SRC_PSM]  = flags.supply_mon_request;
    raw[TLIC_SRC_WDG]  = flags.watchdog_timeout_flag & watchdog_irq_select
                         & watchdog_timeout_nonzero;
    raw[TLIC_SRC_EXT0] = flags.ext0_request;
    raw[TLIC_SRC_ADC]  = flags.primary_adc_done | flags.aux_adc_done;
    raw[TLIC_SRC_TMR0] = flags.timer0_overflow;
    raw[TLIC_SRC_EXT1] = flags.ext1_request;
    raw[TLIC_SRC_TMR1] = flags.timer1_overflow;
    raw[TLIC_SRC_SER]  = flags.two_wire_request | flags.four_wire_request;
    raw[TLIC_SRC_UART] = flags.uart_rx_flag | flags.uart_tx_flag;
    raw[TLIC_SRC_TMR2] = flags.timer2_overflow | flags.timer2_ext_flag;
    raw[TLIC_SRC_TIC]  = flags.interval_ctr_request;
    en[TLIC_SRC_PSM]   = gate & secondary_r[1];
    en[TLIC_SRC_WDG]   = 1'b1;
    en[TLIC_SRC_EXT0]  = gate & ie_primary_r[0];
    en[TLIC_SRC_ADC]   = gate & ie_primary_r[6];
    en[TLIC_SRC_TMR0]  = gate & ie_primary_r[1];
    en[TLIC_SRC_EXT1]  = gate & ie_primary_r[2];
    en[TLIC_SRC_TMR1]  = gate & ie_primary_r[3];
    en[TLIC_SRC_SER]   = gate & secondary_r[0];
    en[TLIC_SRC_UART]  = gate & ie_primary_r[4];
    en[TLIC_SRC_TMR2]  = gate & ie_primary_r[5];
    en[TLIC_SRC_TIC]   = gate & secondary_r[2];
    hi[TLIC_SRC_PSM]   = secondary_r[5];
    hi[TLIC_SRC_WDG]   = 1'b1;
    hi[TLIC_SRC_EXT0]  = priority_r[0];
    hi[TLIC_SRC_ADC]   = priority_r[6];
    hi[TLIC_SRC_TMR0]  = priority_r[1];
    hi[TLIC_SRC_EXT1]  = priority_r[2];
    hi[TLIC_SRC_TMR1]  = priority_r[3];
    hi[TLIC_SRC_SER]   = secondary_r[4];
    hi[TLIC_SRC_UART]  = priority_r[4];
    hi[TLIC_SRC_TMR2]  = priority_r[5];
    hi[TLIC_SRC_TIC]   = secondary_r[6];
  end

  logic [N-1:0]  live;
  logic          hi_any;
  logic          lo_any;
  logic [IW-1:0] hi_idx;
  logic [IW-1:0] lo_idx;

  assign live = raw & en;

  tlic_select #(.N(N)) u_sel_hi (
    .req (live & hi),
    .any (hi_any),
    .idx (hi_idx)
  );

  tlic_select #(.N(N)) u_sel_lo (
    .req (live & ~hi),
    .any (lo_any),
    .idx (lo_idx)
  );

  // active_r[1] = high-level routine running, active_r[0] = low-level
  logic [1:0]    active_r;
  tlic_state_t   state_r;
  logic          win_hi;
  logic          win_lo;
  logic          pick_hi_r;
  logic [IW-1:0] pick_idx_r;

  assign win_hi = hi_any & ~active_r[1];
  assign win_lo = lo_any & ~hi_any & ~(|active_r);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= TLIC_ST_IDLE;
      pick_hi_r  <= 1'b0;
      pick_idx_r <= '0;
      irq_vector <= 16'h0000;
    end else begin
      case (state_r)
        TLIC_ST_IDLE: begin
          if (win_hi || win_lo) begin
            state_r    <= TLIC_ST_ACK;
            pick_hi_r  <= win_hi;
            pick_idx_r <= win_hi ? hi_idx : lo_idx;
            irq_vector <= vec_of(win_hi ? hi_idx : lo_idx);
          end
        end
        TLIC_ST_ACK: begin
          if (core_ready) begin
            state_r <= TLIC_ST_WAIT;
          end
        end
        TLIC_ST_WAIT: begin
          // One cycle for the active level to settle before re-arbitrating
          state_r <= TLIC_ST_IDLE;
        end
        default: state_r <= TLIC_ST_IDLE;
      endcase
    end
  end

  logic accept;
  assign accept      = (state_r == TLIC_ST_ACK) && core_ready;
  assign irq_req     = (state_r == TLIC_ST_ACK);
  assign irq_push_pc = accept;

  // Return retires the higher active level first, as nesting is strictly ordered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 2'b00;
    end else if (accept) begin
      active_r[pick_hi_r ? 1 : 0] <= 1'b1;
    end else if (core_reti) begin
      if (active_r[1]) begin
        active_r[1] <= 1'b0;
      end else begin
        active_r[0] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_taken <= '0;
    end else begin
      irq_taken <= accept ? (N'(1) << pick_idx_r) : '0;
    end
  end

  assign active_levels = active_r;

  property p_gate_off;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_r == TLIC_ST_IDLE && !ie_primary_r[TLIC_GATE_BIT] && !raw[TLIC_SRC_WDG])
      |=> !irq_req;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("request raised with gate closed");

  property p_wdg_vec;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_r == TLIC_ST_IDLE && raw[TLIC_SRC_WDG] && !active_r[1]
       && !(live[TLIC_SRC_PSM] && hi[TLIC_SRC_PSM]))
      |=> irq_req && irq_vector == TLIC_VEC_WDG;
  endproperty
  a_wdg_vec: assert property (p_wdg_vec) else $error("watchdog not vectored");

  property p_no_same_level;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_r == TLIC_ST_IDLE && active_r[1]) |=> !irq_req;
  endproperty
  a_no_same_level: assert property (p_no_same_level) else $error("high nested in high");

  property p_hi_first;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_r == TLIC_ST_IDLE && hi_any && lo_any && active_r == 2'b00)
      |=> pick_hi_r;
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("low chosen over high");

  property p_preempt;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_r == TLIC_ST_IDLE && active_r == 2'b01 && hi_any) |=> irq_req ##0 pick_hi_r;
  endproperty
  a_preempt: assert property (p_preempt) else $error("high did not preempt low");

  property p_vec_match;
    @(posedge ref_clk) disable iff (!rst_n)
      irq_req |-> irq_vector == vec_of(pick_idx_r);
  endproperty
  a_vec_match: assert property (p_vec_match) else $error("vector mismatch");

  property p_push;
    @(posedge ref_clk) disable iff (!rst_n)
      (irq_req && core_ready) |-> irq_push_pc ##1 (irq_taken != '0 && !irq_req);
  endproperty
  a_push: assert property (p_push) else $error("accept without push");

  property p_order;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_r == TLIC_ST_IDLE && win_hi && live[TLIC_SRC_PSM] && hi[TLIC_SRC_PSM])
      |=> irq_vector == TLIC_VEC_PSM;
  endproperty
  a_order: assert property (p_order) else $error("polling order broken");

  property p_wdg_cond;
    @(posedge ref_clk) disable iff (!rst_n)
      (!watchdog_irq_select || !watchdog_timeout_nonzero) |-> !raw[TLIC_SRC_WDG];
  endproperty
  a_wdg_cond: assert property (p_wdg_cond) else $error("watchdog unqualified");

  property p_sec_bits;
    @(posedge ref_clk) disable iff (!rst_n)
      sfr_wr.wr && sfr_wr.addr == TLIC_ADDR_SECONDARY |=> !secondary_r[3] && secondary_r[7];
  endproperty
  a_sec_bits: assert property (p_sec_bits) else $error("reserved bits changed");

  // The core may stall; the request and its vector must not move meanwhile
  property p_req_stands;
    @(posedge ref_clk) disable iff (!rst_n)
      (irq_req && !core_ready) |=> irq_req && $stable(irq_vector);
  endproperty
  a_req_stands: assert property (p_req_stands) else $error("request dropped early");

  property p_taken_onehot;
    @(posedge ref_clk) disable iff (!rst_n)
      irq_push_pc |=> $onehot(irq_taken) && (active_levels[1] || active_levels[0]);
  endproperty
  a_taken_onehot: assert property (p_taken_onehot) else $error("accept not recorded");

  property p_ie_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (sfr_wr.wr && sfr_wr.addr == TLIC_ADDR_IE_PRIMARY)
      |=> ie_primary_r == $past(sfr_wr.wdata);
  endproperty
  a_ie_write: assert property (p_ie_write) else $error("enable write lost");

  property p_prio_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (sfr_wr.wr && sfr_wr.addr == TLIC_ADDR_PRIORITY)
      |=> priority_r == ($past(sfr_wr.wdata) & TLIC_PRIO_WMASK);
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority write lost");

  property p_gate_mask;
    @(posedge ref_clk) disable iff (!rst_n)
      !ie_primary_r[TLIC_GATE_BIT] |-> (live & ~(N'(1) << TLIC_SRC_WDG)) == '0;
  endproperty
  a_gate_mask: assert property (p_gate_mask) else $error("live with gate closed");

  property p_lo_blocked;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_r == TLIC_ST_IDLE && active_r != 2'b00 && !hi_any) |=> !irq_req;
  endproperty
  a_lo_blocked: assert property (p_lo_blocked) else $error("low nested in a routine");

  property p_wdg_hi;
    @(posedge ref_clk) disable iff (!rst_n)
      raw[TLIC_SRC_WDG] |-> live[TLIC_SRC_WDG] && hi[TLIC_SRC_WDG];
  endproperty
  a_wdg_hi: assert property (p_wdg_hi) else $error("watchdog masked or low");
endmodule

// [verification/tlic_core_model.sv]
// Behavioural processor core that fetches interrupt vectors from the controller
`timescale 1ns/10ps
module tlic_core_model
  import tlic_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        stall,
  input  wire logic        irq_req,
  input  wire logic        irq_push_pc,
  input  wire logic [15:0] irq_vector,
  output logic             core_ready,
  output logic [15:0]      pc_r
);
  // Stall mimics a long instruction still running, so the request must wait
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ready <= 1'b0;
    end else begin
      core_ready <= irq_req & ~stall & ~irq_push_pc;
    end
  end
  // On irq_push_pc the vector is loaded into pc_r; no return address is stored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= 16'h0100;
    end else if (irq_push_pc) begin
      pc_r <= irq_vector;
    end
  end
endmodule

// [verification/testbench.sv]
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module testbench
  import tlic_pkg::*;
;
  logic         ref_clk, rst_n, wsel, wnz, core_ready, core_reti, stall;
  tlic_sfr_wr_t sw;
  logic [7:0]   sfr_raddr, sfr_rdata;
  tlic_flags_t  fl;
  logic         irq_req, irq_push_pc;
  logic [15:0]  irq_vector, pc_r;
  logic [10:0]  irq_taken;
  logic [1:0]   active_levels;
  int           failures, n_tests;
  localparam int SRC_OF[15] = '{TLIC_SRC_TIC, TLIC_SRC_TMR2, TLIC_SRC_TMR2, TLIC_SRC_UART,
    TLIC_SRC_UART, TLIC_SRC_SER, TLIC_SRC_SER, TLIC_SRC_TMR1, TLIC_SRC_EXT1, TLIC_SRC_TMR0,
    TLIC_SRC_ADC, TLIC_SRC_ADC, TLIC_SRC_EXT0, TLIC_SRC_WDG, TLIC_SRC_PSM};
  // Enable and level bit per source: 0-7 in the primary registers, 8-15 in the secondary one
  localparam int EN_BIT[11] = '{9, 7, 0, 6, 1, 2, 3, 8, 4, 5, 10};
  localparam int LV_BIT[11] = '{13, 15, 0, 6, 1, 2, 3, 12, 4, 5, 14};

  tlic_ctrl tlic_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_wr(sw),
    .sfr_raddr(sfr_raddr), .sfr_rdata(sfr_rdata), .flags(fl), .watchdog_irq_select(wsel),
    .watchdog_timeout_nonzero(wnz), .core_ready(core_ready), .core_reti(core_reti),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_push_pc(irq_push_pc),
    .irq_taken(irq_taken), .active_levels(active_levels));
  tlic_core_model tlic_core_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
    .irq_req(irq_req), .irq_push_pc(irq_push_pc), .irq_vector(irq_vector),
    .core_ready(core_ready), .pc_r(pc_r));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] vec_of(input int i);
    case (i)
      TLIC_SRC_PSM:  return TLIC_VEC_PSM;
      TLIC_SRC_WDG:  return TLIC_VEC_WDG;
      TLIC_SRC_EXT0: return TLIC_VEC_EXT0;
      TLIC_SRC_ADC:  return TLIC_VEC_ADC;
      TLIC_SRC_TMR0: return TLIC_VEC_TMR0;
      TLIC_SRC_EXT1: return TLIC_VEC_EXT1;
      TLIC_SRC_TMR1: return TLIC_VEC_TMR1;
      TLIC_SRC_SER:  return TLIC_VEC_SER;
      TLIC_SRC_UART: return TLIC_VEC_UART;
      TLIC_SRC_TMR2: return TLIC_VEC_TMR2;
      default:       return TLIC_VEC_TIC;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 sw = '{1'b1, a, d};
    @(posedge ref_clk);
    #1 sw.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    #1 sfr_raddr = a;
    #1 `CHK("sfr_rdata", exp, sfr_rdata)
  endtask

  task automatic idle(input int cyc);
    repeat (cyc) begin
      @(posedge ref_clk);
      #1 `CHK("irq_req", 1'b0, irq_req)
    end
  endtask

  // Waits for the core to take the request, then checks what the core was given
  task automatic take(input int idx, input logic [1:0] lv);
    int n;
    n = 0;
    while (irq_push_pc !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK("irq_push_pc", 1'b1, irq_push_pc)
    `CHK("irq_vector", vec_of(idx), irq_vector)
    @(posedge ref_clk);
    #1 `CHK("irq_taken", 11'h001 << idx, irq_taken)
    `CHK("active_levels", lv, active_levels)
    `CHK("pc", vec_of(idx), pc_r)
  endtask

  task automatic ret(input logic [1:0] lv);
    core_reti = 1'b1;
    @(posedge ref_clk);
    #1 core_reti = 1'b0;
    `CHK("active_levels", lv, active_levels)
  endtask

  task automatic t_regs;
    rd(8'hA8, 8'h00);
    rd(8'hB8, 8'h00);
    rd(8'hA9, 8'hA0);
    wr(8'hB8, 8'hFF);
    rd(8'hB8, 8'h7F);
    wr(8'hA9, 8'hFF);
    rd(8'hA9, 8'hF7);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    wr(8'hB8, 8'h00);
    wr(8'hA9, 8'h00);
    rd(8'hA9, 8'h80);
  endtask

  task automatic t_gate;
    wr(8'hA8, 8'h01);
    fl[12] = 1'b1;
    idle(6);
    wr(8'hA8, 8'h81);
    take(TLIC_SRC_EXT0, 2'b01);
    fl = '0;
    ret(2'b00);
  endtask

  // Every request flag alone, shared vectors included
  task automatic t_each;
    wr(8'hA8, 8'hFF);
    wr(8'hA9, 8'h07);
    wsel = 1'b1;
    wnz = 1'b1;
    for (int k = 0; k < 15; k++) begin
      fl = 15'h0001 << k;
      take(SRC_OF[k], (SRC_OF[k] == TLIC_SRC_WDG) ? 2'b10 : 2'b01);
      fl = '0;
      ret(2'b00);
    end
  endtask

  task automatic t_order;
    wsel = 1'b0;
    fl = '1;
    for (int r = 0; r < 11; r++) begin
      if (r != TLIC_SRC_WDG) begin
        take(r, 2'b01);
        for (int k = 0; k < 15; k++) begin
          if (SRC_OF[k] == r) begin
            fl[k] = 1'b0;
          end
        end
        ret(2'b00);
      end
    end
    idle(6);
    fl = '0;
  endtask

  task automatic t_nest;
    wr(8'hB8, 8'h04);
    fl[9] = 1'b1;
    take(TLIC_SRC_TMR0, 2'b01);
    fl[12] = 1'b1;
    idle(5);
    fl[8] = 1'b1;
    take(TLIC_SRC_EXT1, 2'b11);
    wsel = 1'b1;
    fl[13] = 1'b1;
    idle(5);
    fl[8] = 1'b0;
    ret(2'b01);
    take(TLIC_SRC_WDG, 2'b11);
    fl[13] = 1'b0;
    ret(2'b01);
    idle(4);
    fl[9] = 1'b0;
    ret(2'b00);
    take(TLIC_SRC_EXT0, 2'b01);
    fl = '0;
    ret(2'b00);
    fl[12] = 1'b1;
    fl[8] = 1'b1;
    take(TLIC_SRC_EXT1, 2'b10);
    idle(4);
    fl[8] = 1'b0;
    ret(2'b00);
    take(TLIC_SRC_EXT0, 2'b01);
    fl = '0;
    ret(2'b00);
  endtask

  // Watchdog with the global gate off, and a slow core holding the request
  task automatic t_wdg;
    wr(8'hA8, 8'h01);
    wnz = 1'b0;
    fl[13] = 1'b1;
    idle(6);
    stall = 1'b1;
    wnz = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 `CHK("irq_req", 1'b1, irq_req)
    `CHK("irq_vector", TLIC_VEC_WDG, irq_vector)
    stall = 1'b0;
    take(TLIC_SRC_WDG, 2'b10);
    fl = '0;
    ret(2'b00);
  endtask

  // Reset in mid-service returns everything to its power-on state
  task automatic t_reset;
    wr(TLIC_ADDR_IE_PRIMARY, 8'h81);
    fl[12] = 1'b1;
    take(TLIC_SRC_EXT0, 2'b01);
    @(posedge ref_clk);
    #1 rst_n = 1'b0;
    #1 `CHK("active_levels", 2'b00, active_levels)
    `CHK("irq_req", 1'b0, irq_req)
    `CHK("irq_vector", 16'h0000, irq_vector)
    rd(TLIC_ADDR_SECONDARY, TLIC_RST_SECONDARY);
    rd(TLIC_ADDR_IE_PRIMARY, TLIC_RST_IE_PRIMARY);
    @(posedge ref_clk);
    #1 rst_n = 1'b1;
    idle(4);
    fl = '0;
  endtask

  // One source enabled at a time, raised to high level by its own bit only
  task automatic t_bits;
    logic [15:0] e;
    logic [15:0] p;
    wsel = 1'b0;
    for (int r = 0; r < 11; r++) begin
      if (r != TLIC_SRC_WDG) begin
        e = 16'h0080 | (16'h0001 << EN_BIT[r]);
        p = 16'h0001 << LV_BIT[r];
        wr(TLIC_ADDR_IE_PRIMARY, e[7:0]);
        wr(TLIC_ADDR_PRIORITY, p[7:0]);
        wr(TLIC_ADDR_SECONDARY, e[15:8] | p[15:8]);
        fl = '1;
        take(r, 2'b10);
        fl = '0;
        ret(2'b00);
      end
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    finish_test;
  end

  initial begin
    {rst_n, wsel, wnz, core_reti, stall, sfr_raddr} = '0;
    sw = '0;
    fl = '0;
    failures = 0;
    n_tests = 0;
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_regs;
    t_gate;
    t_each;
    t_order;
    t_nest;
    t_wdg;
    t_reset;
    t_bits;
    finish_test;
  end
endmodule
